// *** inc/rfdp_params.svh ***
/*
  Constants for the RF divider programming words: field positions,
  select codes, reset values and divide-value limits.
  Assumes inclusion by bare name from the package or the RTL.
*/
`ifndef RFDP_PARAMS_SVH
`define RFDP_PARAMS_SVH

`define RFDP_WORD_W 24
// Integer/fraction word
`define RFDP_W0_SEL_POS 0
`define RFDP_W0_SEL_VAL 1'h0
`define RFDP_W0_FN_LSB 1
`define RFDP_W0_FN_MSB 12
`define RFDP_W0_N_LSB 13
`define RFDP_W0_N_MSB 23
// Denominator/reference/power word
`define RFDP_W1_SEL_MSB 3
`define RFDP_W1_SEL_VAL 4'h3
`define RFDP_W1_FD_LSB 4
`define RFDP_W1_FD_MSB 15
`define RFDP_W1_R_LSB 16
`define RFDP_W1_R_MSB 21
`define RFDP_W1_P_POS 22
`define RFDP_W1_PD_POS 23
// Divide value split
`define RFDP_A_LSB 0
`define RFDP_A_MSB 1
`define RFDP_B_LSB 2
`define RFDP_B_MSB 3
`define RFDP_C_LSB 4
`define RFDP_C_MSB 10
`define RFDP_B_WEIGHT 4
// Reset values
`define RFDP_RST_N 11'h01F
`define RFDP_RST_FN 12'h000
`define RFDP_RST_FD 12'h001
`define RFDP_RST_R 6'h01
`define RFDP_RST_P 1'h0
`define RFDP_RST_PD 1'h1
`define RFDP_RST_CE 1'h0
`define RFDP_RST_C 7'h00
`define RFDP_RST_B 2'h0
`define RFDP_RST_A 2'h0
`define RFDP_RST_SPARE 1'h0
`define RFDP_RST_BAD 1'h0
`define RFDP_RST_SYNTH_POWER_DOWN_BIT 1'h1
`define RFDP_RST_CP_OE 1'h0
// Legal divide ranges per prescaler
`define RFDP_P0_MIN 11'h019
`define RFDP_P0_MAX 11'h3FF
`define RFDP_P1_MIN 11'h031
`define RFDP_P1_MAX 11'h7FD

`endif

// *** inc/rfdp_pkg.sv ***
/*
  Types for the RF divider programming block.
  Assumes the params header is on the include path.
*/
package rfdp_pkg;
  `include "rfdp_params.svh"
  typedef logic [10:0] rfdp_divide_t;
  typedef logic [11:0] rfdp_frac_t;
  typedef logic [5:0] rfdp_refdiv_t;
  typedef logic [6:0] rfdp_main_t;
  typedef logic [1:0] rfdp_swallow_t;
endpackage : rfdp_pkg

// *** rtl/rfdp_regs.sv ***
/*
  RF divider programming registers: two loaded words, divide-value
  split into prescaler counts, range flag and RF power-down resolution.
  Assumes the serial shifter delivers a whole 24-bit word with a
  one-cycle load strobe on clk_sys; chip enable arrives from a pin.
  Assumes auto_power_up comes from logic on clk_sys, so it is not
  synchronised; the chip enable pin is, and costs three edges of latency.
  The range flag only reports; a word outside the legal window is still
  loaded, because the host owns legality and the modulator order is not
  visible here.
  Every output is a flip-flop; derived counts are computed from the next
  divide value so they never lag the word registers by a cycle.
  Reset values of the derived counts are zero and differ from the split
  of the reset divide value for one edge after release.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rfdp_params.svh"

module rfdp_regs
  import rfdp_pkg::*;
(
  // Clock, reset and the word handed over by the serial shifter
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`RFDP_WORD_W-1:0] load_word,
  input wire logic load_strobe,
  input wire logic auto_power_up,
  input wire logic chip_enable_pin,
  // Fields as loaded
  output logic [10:0] integer_divide_value,
  output logic [11:0] frac_numerator,
  output logic [11:0] frac_denominator,
  output logic [5:0] reference_divider,
  output logic prescaler_select,
  output logic synth_power_down_bit,
  // Prescaler counts and status, all registered
  output logic [6:0] main_counter_value,
  output logic [1:0] swallow_quad_count,
  output logic [1:0] swallow_low_count,
  output logic swallow_spare_bit,
  output logic divide_out_of_range,
  output logic rf_power_down,
  output logic cp_output_enable
);

  // Derived divide split; A is the low pair, B the next, main the rest
  function automatic rfdp_main_t main_of(input rfdp_divide_t n);
    main_of = n[`RFDP_C_MSB:`RFDP_C_LSB];
  endfunction : main_of

  // Legal window per prescaler; order-dependent limits are not seen here
  function automatic logic range_bad(input rfdp_divide_t n, input logic p);
    if (p) begin
      // Large prescaler window
      range_bad = (n < `RFDP_P1_MIN) || (n > `RFDP_P1_MAX);
    end else begin
      // Small prescaler window
      range_bad = (n < `RFDP_P0_MIN) || (n > `RFDP_P0_MAX);
    end
  endfunction : range_bad

  // Synchroniser stages
  logic ce_meta;
  logic ce_sync;
  logic next_ce_meta;
  logic next_ce_sync;

  // Next values of the loaded fields
  rfdp_divide_t next_n;
  rfdp_frac_t next_fn;
  rfdp_frac_t next_fd;
  rfdp_refdiv_t next_r;
  logic next_p;
  logic next_pd;

  // Next values of the derived outputs
  rfdp_main_t next_c;
  rfdp_swallow_t next_b;
  rfdp_swallow_t next_a;
  logic next_spare;
  logic next_bad;
  logic next_synth_power_down_bit;
  logic next_cp_oe;

  // Select strobes, one per recognised word
  logic sel_int;
  logic sel_den;

  // Chip enable pin synchroniser, first stage feeds only the second
  // Reset to disabled so the loop stays down until the pin is seen
  always_comb begin
    next_ce_meta = chip_enable_pin;
    next_ce_sync = ce_meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ce_meta <= `RFDP_RST_CE;
      ce_sync <= `RFDP_RST_CE;
    end else begin
      ce_meta <= next_ce_meta;
      ce_sync <= next_ce_sync;
    end
  end

  // Word decode and field loading
  always_comb begin
    sel_int = load_strobe && (load_word[`RFDP_W0_SEL_POS] == `RFDP_W0_SEL_VAL);
    sel_den = load_strobe && (load_word[`RFDP_W1_SEL_MSB:0] == `RFDP_W1_SEL_VAL);
    // Hold every field unless a matching word strobes
    next_n = integer_divide_value;
    next_fn = frac_numerator;
    next_fd = frac_denominator;
    next_r = reference_divider;
    next_p = prescaler_select;
    next_pd = synth_power_down_bit;

    // Divide and numerator move together, so one write retunes
    if (sel_int) begin
      next_n = load_word[`RFDP_W0_N_MSB:`RFDP_W0_N_LSB];
      next_fn = load_word[`RFDP_W0_FN_MSB:`RFDP_W0_FN_LSB];
      // Auto power-up clears the stored bit rather than masking it
      if (auto_power_up) begin
        next_pd = 1'h0;
      end
    end

    // Second word; selects are disjoint, so no clash with the clear above
    if (sel_den) begin
      next_fd = load_word[`RFDP_W1_FD_MSB:`RFDP_W1_FD_LSB];
      next_r = load_word[`RFDP_W1_R_MSB:`RFDP_W1_R_LSB];
      next_p = load_word[`RFDP_W1_P_POS];
      next_pd = load_word[`RFDP_W1_PD_POS];
    end
  end

  // Loaded fields; reset gives a legal small-prescaler setting
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      integer_divide_value <= `RFDP_RST_N;
      frac_numerator <= `RFDP_RST_FN;
      frac_denominator <= `RFDP_RST_FD;
      reference_divider <= `RFDP_RST_R;
      prescaler_select <= `RFDP_RST_P;
      synth_power_down_bit <= `RFDP_RST_PD;
    end else begin
      integer_divide_value <= next_n;
      frac_numerator <= next_fn;
      frac_denominator <= next_fd;
      reference_divider <= next_r;
      prescaler_select <= next_p;
      synth_power_down_bit <= next_pd;
    end
  end

  // Counter split and range flag, computed from next values so the
  // outputs follow a load on the same edge as the word registers
  always_comb begin
    next_c = main_of(next_n);
    next_b = next_n[`RFDP_B_MSB:`RFDP_B_LSB];
    next_a = next_n[`RFDP_A_MSB:`RFDP_A_LSB];
    // Spare when B never needs its top bit; modulator may borrow it
    next_spare = ~next_b[1];
    // Only flags, the host owns legality (order limits not checked here)
    next_bad = range_bad(next_n, next_p);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_counter_value <= `RFDP_RST_C;
      swallow_quad_count <= `RFDP_RST_B;
      swallow_low_count <= `RFDP_RST_A;
      swallow_spare_bit <= `RFDP_RST_SPARE;
      divide_out_of_range <= `RFDP_RST_BAD;
    end else begin
      main_counter_value <= next_c;
      swallow_quad_count <= next_b;
      swallow_low_count <= next_a;
      swallow_spare_bit <= next_spare;
      divide_out_of_range <= next_bad;
    end
  end

  // Power resolution: pin first, then the stored bit; auto power-up has
  // already acted on that bit when the integer word was taken
  always_comb begin
    if (!ce_sync) begin
      next_synth_power_down_bit = 1'h1;
    end else begin
      next_synth_power_down_bit = next_pd;
    end
    // Charge pump floats whenever the loop is down
    next_cp_oe = ~next_synth_power_down_bit;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rf_power_down <= `RFDP_RST_SYNTH_POWER_DOWN_BIT;
      cp_output_enable <= `RFDP_RST_CP_OE;
    end else begin
      rf_power_down <= next_synth_power_down_bit;
      cp_output_enable <= next_cp_oe;
    end
  end

endmodule : rfdp_regs
`default_nettype wire

// *** bench/rfdp_regs_properties.sv ***
/* Checker for rfdp_regs: word loads, counter split, spare bit, power-down.
   Assumes a bind to rfdp_regs; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rfdp_regs_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load_strobe,
  input wire logic auto_power_up,
  input wire logic chip_enable_pin,
  input wire logic [23:0] load_word,
  input wire logic [10:0] integer_divide_value,
  input wire logic [11:0] frac_numerator,
  input wire logic [11:0] frac_denominator,
  input wire logic [5:0] reference_divider,
  input wire logic [6:0] main_counter_value,
  input wire logic [1:0] swallow_quad_count,
  input wire logic [1:0] swallow_low_count,
  input wire logic prescaler_select,
  input wire logic synth_power_down_bit,
  input wire logic swallow_spare_bit,
  input wire logic divide_out_of_range,
  input wire logic rf_power_down,
  input wire logic cp_output_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Select decodes; any other strobed word must leave the fields alone
  sequence s_int_load; load_strobe && !load_word[0]; endsequence
  sequence s_w1_load; load_strobe && load_word[3:0] == 4'h3; endsequence
  sequence s_ce_low; !chip_enable_pin [*3]; endsequence
  property p_int; s_int_load |=> {integer_divide_value, frac_numerator} == $past(load_word[23:1]); endproperty
  a_int: assert property (p_int) else $error("integer word");
  property p_w1; s_w1_load |=> {prescaler_select, reference_divider, frac_denominator} == $past(load_word[22:4]);
  endproperty
  a_w1: assert property (p_w1) else $error("second word");
  property p_keep;
    !(load_strobe && (!load_word[0] || load_word[3:0] == 4'h3)) |=>
      $stable({integer_divide_value, frac_numerator, frac_denominator, reference_divider, prescaler_select});
  endproperty
  a_keep: assert property (p_keep) else $error("stray load");
  // Derived counts lag reset release by one edge
  property p_split; $past(rst_n) |-> {main_counter_value, swallow_quad_count, swallow_low_count} == integer_divide_value;
  endproperty
  a_split: assert property (p_split) else $error("split");
  property p_spare; $past(rst_n) |-> swallow_spare_bit == !swallow_quad_count[1]; endproperty
  a_spare: assert property (p_spare) else $error("spare");
  property p_cp; cp_output_enable == !rf_power_down; endproperty
  a_cp: assert property (p_cp) else $error("charge pump");
  property p_ce; s_ce_low |=> rf_power_down; endproperty
  a_ce: assert property (p_ce) else $error("chip enable");
  property p_auto_power_up; s_int_load ##0 auto_power_up |=> !synth_power_down_bit; endproperty
  a_auto_power_up: assert property (p_auto_power_up) else $error("auto power-up");
  property p_pd; chip_enable_pin [*4] ##0 $stable(synth_power_down_bit) |-> rf_power_down == synth_power_down_bit;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down bit");
endmodule : rfdp_regs_properties
bind rfdp_regs rfdp_regs_properties i_rfdp_regs_properties (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .load_strobe(load_strobe),
  .auto_power_up(auto_power_up),
  .chip_enable_pin(chip_enable_pin),
  .load_word(load_word),
  .integer_divide_value(integer_divide_value),
  .frac_numerator(frac_numerator),
  .frac_denominator(frac_denominator),
  .reference_divider(reference_divider),
  .main_counter_value(main_counter_value),
  .swallow_quad_count(swallow_quad_count),
  .swallow_low_count(swallow_low_count),
  .prescaler_select(prescaler_select),
  .synth_power_down_bit(synth_power_down_bit),
  .swallow_spare_bit(swallow_spare_bit),
  .divide_out_of_range(divide_out_of_range),
  .rf_power_down(rf_power_down),
  .cp_output_enable(cp_output_enable)
);
`default_nettype wire

// *** bench/rfdp_host.sv ***
/* Host model: whole 24-bit words with a one-cycle strobe.
   Assumes clk_sys from the bench. */
`timescale 1ns/1ps
`default_nettype none
module rfdp_host (
  input wire logic clk_sys,
  output logic [23:0] load_word,
  output logic load_strobe
);
  initial begin
    load_word = 24'h000000;
    load_strobe = 1'h0;
  end
  // Callers pick legal divide values, bar range-flag probes; idle bus shows the inverse word
  task automatic send(input logic [23:0] w);
    @(posedge clk_sys);
    load_word <= w;
    load_strobe <= 1'h1;
    @(posedge clk_sys);
    load_strobe <= 1'h0;
    load_word <= ~w;
  endtask : send
endmodule : rfdp_host
`default_nettype wire

// *** bench/rfdp_regs_bench.sv ***
/* Bench for rfdp_regs, one task per scenario.
   Assumes design, checker and host model compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module rfdp_regs_bench;
  logic clk_sys, rst_n, load_strobe, auto_power_up, chip_enable_pin, prescaler_select, synth_power_down_bit;
  logic swallow_spare_bit, divide_out_of_range, rf_power_down, cp_output_enable;
  logic [23:0] load_word;
  logic [10:0] integer_divide_value;
  logic [11:0] frac_numerator, frac_denominator;
  logic [5:0] reference_divider;
  logic [6:0] main_counter_value;
  logic [1:0] swallow_quad_count, swallow_low_count;
  int err_count = 0;
  int tests_run = 0;
  rfdp_regs i_rfdp_regs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load_word(load_word),
    .load_strobe(load_strobe),
    .auto_power_up(auto_power_up),
    .chip_enable_pin(chip_enable_pin),
    .integer_divide_value(integer_divide_value),
    .frac_numerator(frac_numerator),
    .frac_denominator(frac_denominator),
    .reference_divider(reference_divider),
    .prescaler_select(prescaler_select),
    .synth_power_down_bit(synth_power_down_bit),
    .main_counter_value(main_counter_value),
    .swallow_quad_count(swallow_quad_count),
    .swallow_low_count(swallow_low_count),
    .swallow_spare_bit(swallow_spare_bit),
    .divide_out_of_range(divide_out_of_range),
    .rf_power_down(rf_power_down),
    .cp_output_enable(cp_output_enable)
  );
  rfdp_host i_rfdp_host (
    .clk_sys(clk_sys),
    .load_word(load_word),
    .load_strobe(load_strobe)
  );
  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Send then settle; power-down goes through the pin synchroniser
  task automatic put(input logic [23:0] w, input int n);
    i_rfdp_host.send(w);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : put
  task automatic t_words();
    put({11'h037, 12'h5A5, 1'h0}, 0);
    `CHK("int", {11'h037, 12'h5A5}, {integer_divide_value, frac_numerator})
    `CHK("split", {7'h03, 2'h1, 2'h3}, {main_counter_value, swallow_quad_count, swallow_low_count})
    `CHK("spare", 1'h1, swallow_spare_bit)
    `CHK("range_ok", 1'h0, divide_out_of_range)
    put({1'h0, 1'h1, 6'h01, 12'hABC, 4'h3}, 3);
    `CHK("w1", {12'hABC, 6'h01, 1'h1}, {frac_denominator, reference_divider, prescaler_select})
    `CHK("w1_run", 3'h1, {divide_out_of_range, rf_power_down, cp_output_enable})
    put({11'h7FE, 12'h000, 1'h0}, 0);
    `CHK("range", 1'h1, divide_out_of_range)
    put(24'hFFFFF5, 0);
    `CHK("ignore", 23'h7FEABC, {integer_divide_value, frac_denominator})
  endtask : t_words
  task automatic t_power();
    put({1'h1, 1'h0, 6'h3F, 12'h001, 4'h3}, 3);
    `CHK("pd", 2'h2, {rf_power_down, cp_output_enable})
    `CHK("range_small", 1'h1, divide_out_of_range)
    @(posedge clk_sys);
    auto_power_up <= 1'h1;
    chip_enable_pin <= 1'h0;
    put({11'h3FF, 12'h000, 1'h0}, 4);
    `CHK("ce", 3'h4, {rf_power_down, cp_output_enable, synth_power_down_bit})
    `CHK("range_top", 1'h0, divide_out_of_range)
    @(posedge clk_sys);
    chip_enable_pin <= 1'h1;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("auto_power_up", 2'h1, {rf_power_down, cp_output_enable})
  endtask : t_power
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 1'h0;
    auto_power_up = 1'h0;
    chip_enable_pin = 1'h1;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_words();
    t_power();
    wrap_up();
  end
  // Whole run is under 100 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule : rfdp_regs_bench
`default_nettype wire
